/* aie_exec.sv */
// The implementer's own choices: strobed register access and the register offsets.
`include "aie_map.svh"
module aie_exec #(
  parameter int DMEM_DEPTH = 192,
  parameter int STACK_DEPTH = 8,
  parameter int PC_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic issue_valid,
  input wire logic [4:0] issue_op,
  input wire logic [7:0] issue_imm,
  input wire logic [7:0] issue_addr,
  output logic issue_ready,
  input wire logic call_valid,
  input wire logic [PC_W-1:0] call_target,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [PC_W-1:0] pc_out,
  output logic [7:0] acc_out,
  output logic carry_flag,
  output logic nibble_carry_flag,
  output logic zero_flag,
  output logic signed_wrap_flag,
  output logic global_irq_enable,
  output logic discard_fetch,
  output logic retire
);
  // Zero test shared by the zero flag and the skip decision.
  function automatic logic aie_is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction : aie_is_zero

  // Address check shared by instruction and register port accesses.
  // The compare is done at 32 bits, so a depth of 256 still works.
  function automatic logic aie_in_dmem(input logic [7:0] addr);
    return 32'(addr) < DMEM_DEPTH;
  endfunction : aie_in_dmem

  aie_pkg::aie_state_t state_q;
  aie_pkg::aie_op_t op;
  logic [7:0] acc_q;
  logic carry_q;
  logic nib_q;
  logic zero_q;
  logic wrap_q;
  logic irq_en_q;
  logic [PC_W-1:0] pc_q;
  logic [7:0] dmem_q [DMEM_DEPTH];
  logic [7:0] rdata_q;
  logic [7:0] rd_mux;
  logic [7:0] mem_val;
  logic [15:0] pc_wide;
  logic discard_q;
  logic retire_q;
  logic take;
  logic is_ret;
  logic skip;
  logic call_take;
  logic stat_wr;
  logic acc_wr;
  logic acc_load;
  logic mem_store;
  logic carry_upd;
  logic zero_upd;
  logic arith_upd;
  logic exit_take;

  aie_alu_if alu_bus ();
  aie_stack_if #(.AW(PC_W)) stk_bus ();

  aie_alu u_alu (
    .a(alu_bus.alu)
  );

  // Return stack; a call past its depth overwrites the oldest return address.
  aie_stack #(
    .DEPTH(STACK_DEPTH),
    .AW(PC_W)
  ) u_stack (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .s(stk_bus.stack)
  );

  // An instruction is taken only in a run cycle; the dummy cycle refuses it.
  assign issue_ready = (state_q == aie_pkg::aie_st_run);
  assign take = issue_valid && issue_ready;
  assign op = aie_pkg::aie_op_t'(issue_op);

  // Operand byte; addresses past the memory read as zero.
  // The read is combinational, so issue_addr must be settled before the taking edge.
  assign mem_val = aie_in_dmem(issue_addr) ? dmem_q[issue_addr] : 8'h00;

  // Datapath operands.
  assign alu_bus.op = op;
  assign alu_bus.acc = acc_q;
  assign alu_bus.mem = mem_val;
  assign alu_bus.imm = issue_imm;
  assign alu_bus.carry_in = carry_q;

  // Return decode covers all three stack pops.
  assign is_ret = (op == aie_pkg::op_pop_to_pc) || (op == aie_pkg::op_pop_to_pc_imm) ||
    (op == aie_pkg::op_interrupt_exit);
  assign skip = take && alu_bus.dec_test && aie_is_zero(alu_bus.result);

  // A call from the sequencer is honoured only when no instruction competes.
  assign call_take = call_valid && !issue_valid && issue_ready;
  assign stk_bus.push = call_take;
  assign stk_bus.push_pc = pc_q + PC_W'(`AIE_PC_STEP);
  assign stk_bus.pop = take && is_ret;

  // Register port writes that land on core state.
  assign acc_wr = reg_wr && (reg_addr == `AIE_REG_ACC);
  assign stat_wr = reg_wr && (reg_addr == `AIE_REG_STAT);

  // Enables of the executing instruction; a register port write on the same edge loses.
  // This way software can never undo half of an instruction.
  assign acc_load = take && alu_bus.wr_acc;
  assign mem_store = take && alu_bus.wr_mem && aie_in_dmem(issue_addr);
  assign carry_upd = take && alu_bus.upd_carry;
  assign zero_upd = take && alu_bus.upd_zero;
  assign arith_upd = take && alu_bus.upd_arith;
  assign exit_take = take && (op == aie_pkg::op_interrupt_exit);

  // Phase control: returns and taken skips occupy a second, dummy cycle.
  // Nothing executes in the dummy cycle; it stands in for the word being refetched.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= aie_pkg::aie_st_run;
    end else begin
      unique case (state_q)
        aie_pkg::aie_st_run: begin
          if (take && (is_ret || skip)) begin
            state_q <= aie_pkg::aie_st_dummy;
          end
        end
        aie_pkg::aie_st_dummy: begin
          state_q <= aie_pkg::aie_st_run;
        end
      endcase
    end
  end

  // Program counter; a taken skip steps over the dropped word in one go.
  // A call is only taken in an idle run cycle, so it never meets a pop.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_q <= PC_W'(`AIE_PC_RST);
    end else if (take && is_ret) begin
      pc_q <= stk_bus.top_pc;
    end else if (skip) begin
      pc_q <= pc_q + PC_W'(`AIE_PC_SKIP);
    end else if (take) begin
      pc_q <= pc_q + PC_W'(`AIE_PC_STEP);
    end else if (call_take) begin
      pc_q <= call_target;
    end
  end

  // Accumulator; an executing instruction wins over a register port write.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= `AIE_ACC_RST;
    end else if (acc_load) begin
      // Loads, OR, rotates, subtract and decrement forms that target the accumulator.
      acc_q <= alu_bus.result;
    end else if (acc_wr) begin
      acc_q <= reg_wdata;
    end
  end

  // Carry flag; only the through-carry rotates and the subtracts touch it.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      carry_q <= `AIE_FLAG_RST;
    end else if (carry_upd) begin
      carry_q <= alu_bus.carry_out;
    end else if (stat_wr) begin
      carry_q <= reg_wdata[`AIE_BIT_CARRY];
    end
  end

  // Nibble carry moves only on the subtract forms.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      nib_q <= `AIE_FLAG_RST;
    end else if (arith_upd) begin
      nib_q <= alu_bus.nib_out;
    end else if (stat_wr) begin
      nib_q <= reg_wdata[`AIE_BIT_NIB];
    end
  end

  // Signed wrap moves only on the subtract forms as well.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrap_q <= `AIE_FLAG_RST;
    end else if (arith_upd) begin
      wrap_q <= alu_bus.wrap_out;
    end else if (stat_wr) begin
      wrap_q <= reg_wdata[`AIE_BIT_WRAP];
    end
  end

  // Zero flag follows the 8-bit result wherever an instruction updates it.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      zero_q <= `AIE_FLAG_RST;
    end else if (zero_upd) begin
      zero_q <= aie_is_zero(alu_bus.result);
    end else if (stat_wr) begin
      zero_q <= reg_wdata[`AIE_BIT_ZERO];
    end
  end

  // Global interrupt enable; interrupt exit sets it and wins over software.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_q <= `AIE_FLAG_RST;
    end else if (exit_take) begin
      irq_en_q <= 1'b1;
    end else if (stat_wr) begin
      irq_en_q <= reg_wdata[`AIE_BIT_IRQEN];
    end
  end

  // Data memory; writes past the end are dropped, instruction writes win.
  always_ff @(posedge ref_clk) begin
    if (mem_store) begin
      // Store, OR to memory, rotates, subtract and decrement write back here.
      dmem_q[issue_addr] <= alu_bus.result;
    end else if (reg_wr && aie_in_dmem(reg_addr)) begin
      dmem_q[reg_addr] <= reg_wdata;
    end
  end

  // Register read decode; unmapped addresses read as zero.
  // Data memory fills the bottom of the page and the core registers sit at its top.
  // They are accumulator, status, program counter low and high, then the phase bit.
  // The counter bytes are not latched together, so read them while nothing executes.
  assign pc_wide = 16'(pc_q);
  always_comb begin
    rd_mux = 8'h00;
    if (aie_in_dmem(reg_addr)) begin
      rd_mux = dmem_q[reg_addr];
    end else begin
      unique case (reg_addr)
        `AIE_REG_ACC: begin
          rd_mux = acc_q;
        end
        `AIE_REG_STAT: begin
          rd_mux[`AIE_BIT_CARRY] = carry_q;
          rd_mux[`AIE_BIT_NIB] = nib_q;
          rd_mux[`AIE_BIT_ZERO] = zero_q;
          rd_mux[`AIE_BIT_WRAP] = wrap_q;
          rd_mux[`AIE_BIT_IRQEN] = irq_en_q;
        end
        `AIE_REG_PCLO: begin
          rd_mux = pc_wide[7:0];
        end
        `AIE_REG_PCHI: begin
          rd_mux = pc_wide[15:8];
        end
        `AIE_REG_STATE: begin
          rd_mux = {7'h00, state_q};
        end
        default: begin
          rd_mux = 8'h00;
        end
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  // Clearing between reads keeps a stale byte from looking like a fresh answer.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Discard pulse: the sequencer must drop its prefetched word on a skip.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      discard_q <= 1'b0;
    end else begin
      discard_q <= skip;
    end
  end

  // Retire pulse: one for each instruction taken, none for a dummy cycle.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      retire_q <= 1'b0;
    end else begin
      retire_q <= take;
    end
  end

  // Outputs come straight from flip-flops.
  // Only issue_ready is decoded from state, as a handshake output may be.
  assign reg_rdata = rdata_q;
  assign pc_out = pc_q;
  assign acc_out = acc_q;
  assign carry_flag = carry_q;
  assign nibble_carry_flag = nib_q;
  assign zero_flag = zero_q;
  assign signed_wrap_flag = wrap_q;
  assign global_irq_enable = irq_en_q;
  assign discard_fetch = discard_q;
  assign retire = retire_q;
endmodule : aie_exec

/* aie_map.svh */
`ifndef AIE_MAP_SVH
`define AIE_MAP_SVH
// Register port map: data memory bytes sit below the first core register.
`define AIE_DMEM_BASE 8'h00
`define AIE_REG_ACC 8'hF0
`define AIE_REG_STAT 8'hF1
`define AIE_REG_PCLO 8'hF2
`define AIE_REG_PCHI 8'hF3
`define AIE_REG_STATE 8'hF4
// Bit positions inside the status register.
`define AIE_BIT_CARRY 0
`define AIE_BIT_NIB 1
`define AIE_BIT_ZERO 2
`define AIE_BIT_WRAP 3
`define AIE_BIT_IRQEN 4
// Reset values.
`define AIE_ACC_RST 8'h00
`define AIE_FLAG_RST 1'b0
`define AIE_PC_RST 16'h0000
// Program counter steps: one for a normal step, two when a fetch is dropped.
`define AIE_PC_STEP 16'h0001
`define AIE_PC_SKIP 16'h0002
`endif

/* aie_pkg.sv */
package aie_pkg;
  // Operation codes presented by the program sequencer.
  typedef enum logic [4:0] {
    op_idle_step = 5'h00,
    op_load_acc_from_mem = 5'h01,
    op_load_acc_imm = 5'h02,
    op_store_acc_to_mem = 5'h03,
    op_union_acc_mem = 5'h04,
    op_union_acc_imm = 5'h05,
    op_bitwise_union_to_mem = 5'h06,
    op_pop_to_pc = 5'h07,
    op_pop_to_pc_imm = 5'h08,
    op_interrupt_exit = 5'h09,
    op_rotate_left = 5'h0A,
    op_rotate_left_to_acc = 5'h0B,
    op_rotate_left_thru_borrow_bit = 5'h0C,
    op_rotate_left_thru_borrow_bit_acc = 5'h0D,
    op_rotate_right = 5'h0E,
    op_rotate_right_to_acc = 5'h0F,
    op_rotate_right_thru_borrow_bit = 5'h10,
    op_rotate_right_thru_borrow_bit_acc = 5'h11,
    op_sub_with_borrow = 5'h12,
    op_sub_with_borrow_to_mem = 5'h13,
    op_dec_skip_zero = 5'h14,
    op_dec_skip_zero_acc = 5'h15
  } aie_op_t;

  // Execution phase: a normal cycle or the dummy second cycle.
  typedef enum logic [0:0] {
    aie_st_run = 1'b0,
    aie_st_dummy = 1'b1
  } aie_state_t;
endpackage : aie_pkg

/* aie_if.sv */
// Operand and result bundle between the core and its combinational datapath.
interface aie_alu_if;
  aie_pkg::aie_op_t op;
  logic [7:0] acc;
  logic [7:0] mem;
  logic [7:0] imm;
  logic carry_in;
  logic [7:0] result;
  logic carry_out;
  logic nib_out;
  logic wrap_out;
  logic wr_acc;
  logic wr_mem;
  logic upd_zero;
  logic upd_carry;
  logic upd_arith;
  logic dec_test;
  modport alu (input op, acc, mem, imm, carry_in, output result, carry_out, nib_out,
    wrap_out, wr_acc, wr_mem, upd_zero, upd_carry, upd_arith, dec_test);
  modport core (output op, acc, mem, imm, carry_in, input result, carry_out, nib_out,
    wrap_out, wr_acc, wr_mem, upd_zero, upd_carry, upd_arith, dec_test);
endinterface : aie_alu_if

// Return stack push and pop bundle.
interface aie_stack_if #(parameter int AW = 12);
  logic push;
  logic pop;
  logic [AW-1:0] push_pc;
  logic [AW-1:0] top_pc;
  modport stack (input push, pop, push_pc, output top_pc);
  modport core (output push, pop, push_pc, input top_pc);
endinterface : aie_stack_if

/* aie_alu.sv */
module aie_alu (
  aie_alu_if.alu a
);
  // Circular rotations are shared by the memory and accumulator forms.
  function automatic logic [7:0] aie_rol(input logic [7:0] v);
    return {v[6:0], v[7]};
  endfunction : aie_rol

  function automatic logic [7:0] aie_ror(input logic [7:0] v);
    return {v[0], v[7:1]};
  endfunction : aie_ror

  logic [8:0] sum9;
  logic [4:0] sum5;

  // Subtract is an add of the inverted operand plus the carry flag.
  assign sum9 = 9'({1'b0, a.acc}) + 9'({1'b0, ~a.mem}) + 9'(a.carry_in);
  assign sum5 = 5'({1'b0, a.acc[3:0]}) + 5'({1'b0, ~a.mem[3:0]}) + 5'(a.carry_in);

  // Result and write-back selection per operation; every path sets every output.
  always_comb begin
    a.result = 8'h00;
    a.carry_out = a.carry_in;
    a.nib_out = sum5[4];
    a.wrap_out = (a.acc[7] == ~a.mem[7]) && (sum9[7] != a.acc[7]);
    a.wr_acc = 1'b0;
    a.wr_mem = 1'b0;
    a.upd_zero = 1'b0;
    a.upd_carry = 1'b0;
    a.upd_arith = 1'b0;
    a.dec_test = 1'b0;
    unique case (a.op)
      aie_pkg::op_idle_step, aie_pkg::op_pop_to_pc, aie_pkg::op_interrupt_exit: begin
        a.result = 8'h00;
      end
      aie_pkg::op_load_acc_from_mem: begin
        a.result = a.mem;
        a.wr_acc = 1'b1;
      end
      aie_pkg::op_load_acc_imm, aie_pkg::op_pop_to_pc_imm: begin
        a.result = a.imm;
        a.wr_acc = 1'b1;
      end
      aie_pkg::op_store_acc_to_mem: begin
        a.result = a.acc;
        a.wr_mem = 1'b1;
      end
      aie_pkg::op_union_acc_mem: begin
        a.result = a.acc | a.mem;
        a.wr_acc = 1'b1;
        a.upd_zero = 1'b1;
      end
      aie_pkg::op_union_acc_imm: begin
        a.result = a.acc | a.imm;
        a.wr_acc = 1'b1;
        a.upd_zero = 1'b1;
      end
      aie_pkg::op_bitwise_union_to_mem: begin
        a.result = a.acc | a.mem;
        a.wr_mem = 1'b1;
        a.upd_zero = 1'b1;
      end
      aie_pkg::op_rotate_left, aie_pkg::op_rotate_left_to_acc: begin
        a.result = aie_rol(a.mem);
        a.wr_mem = (a.op == aie_pkg::op_rotate_left);
        a.wr_acc = (a.op == aie_pkg::op_rotate_left_to_acc);
      end
      aie_pkg::op_rotate_left_thru_borrow_bit,
      aie_pkg::op_rotate_left_thru_borrow_bit_acc: begin
        a.result = {a.mem[6:0], a.carry_in};
        a.carry_out = a.mem[7];
        a.upd_carry = 1'b1;
        a.wr_mem = (a.op == aie_pkg::op_rotate_left_thru_borrow_bit);
        a.wr_acc = (a.op == aie_pkg::op_rotate_left_thru_borrow_bit_acc);
      end
      aie_pkg::op_rotate_right, aie_pkg::op_rotate_right_to_acc: begin
        a.result = aie_ror(a.mem);
        a.wr_mem = (a.op == aie_pkg::op_rotate_right);
        a.wr_acc = (a.op == aie_pkg::op_rotate_right_to_acc);
      end
      aie_pkg::op_rotate_right_thru_borrow_bit,
      aie_pkg::op_rotate_right_thru_borrow_bit_acc: begin
        a.result = {a.carry_in, a.mem[7:1]};
        a.carry_out = a.mem[0];
        a.upd_carry = 1'b1;
        a.wr_mem = (a.op == aie_pkg::op_rotate_right_thru_borrow_bit);
        a.wr_acc = (a.op == aie_pkg::op_rotate_right_thru_borrow_bit_acc);
      end
      aie_pkg::op_sub_with_borrow, aie_pkg::op_sub_with_borrow_to_mem: begin
        a.result = sum9[7:0];
        a.carry_out = sum9[8];
        a.upd_arith = 1'b1;
        a.upd_zero = 1'b1;
        a.upd_carry = 1'b1;
        a.wr_acc = (a.op == aie_pkg::op_sub_with_borrow);
        a.wr_mem = (a.op == aie_pkg::op_sub_with_borrow_to_mem);
      end
      aie_pkg::op_dec_skip_zero, aie_pkg::op_dec_skip_zero_acc: begin
        a.result = a.mem - 8'h01;
        a.dec_test = 1'b1;
        a.wr_mem = (a.op == aie_pkg::op_dec_skip_zero);
        a.wr_acc = (a.op == aie_pkg::op_dec_skip_zero_acc);
      end
      default: begin
        // Undefined codes behave as an idle step.
        a.result = 8'h00;
      end
    endcase
  end
endmodule : aie_alu

/* aie_stack.sv */
module aie_stack #(
  parameter int DEPTH = 8,
  parameter int AW = 12
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  aie_stack_if.stack s
);
  localparam int PW = $clog2(DEPTH);

  logic [AW-1:0] slot_q [DEPTH];
  logic [PW-1:0] ptr_q;
  logic [PW-1:0] top_idx;

  // The pointer wraps, so an overflow silently overwrites the oldest entry.
  assign top_idx = ptr_q - PW'(1);
  assign s.top_pc = slot_q[top_idx];

  // Pointer movement; a push and pop together replace the top entry.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q <= '0;
    end else if (s.push && !s.pop) begin
      ptr_q <= ptr_q + PW'(1);
    end else if (s.pop && !s.push) begin
      ptr_q <= top_idx;
    end
  end

  // Entry storage needs no reset; nothing reads an entry before it is pushed.
  always_ff @(posedge ref_clk) begin
    if (s.push) begin
      slot_q[s.pop ? top_idx : ptr_q] <= s.push_pc;
    end
  end
endmodule : aie_stack

/* aie_exec_props.sv */
module aie_exec_props #(
  parameter int PC_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic issue_valid,
  input wire logic [4:0] issue_op,
  input wire logic [7:0] issue_imm,
  input wire logic issue_ready,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic [7:0] acc_out,
  input wire logic carry_flag,
  input wire logic nibble_carry_flag,
  input wire logic zero_flag,
  input wire logic signed_wrap_flag,
  input wire logic global_irq_enable,
  input wire logic discard_fetch,
  input wire logic retire
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // An instruction counts only on an edge where the core was ready for it.
  logic take;
  logic [3:0] flags;
  assign take = issue_valid && issue_ready;
  assign flags = {signed_wrap_flag, zero_flag, nibble_carry_flag, carry_flag};
  chk_idle_pc_step: assert property (take && issue_op == 5'h00 |=>
    pc_out == $past(pc_out) + 1'b1 && $stable(acc_out) && $stable(flags) && retire)
    else $error("idle step changed more than the program counter");
  chk_imm_load_acc: assert property (take && issue_op == 5'h02 |=>
    acc_out == $past(issue_imm) && $stable(flags)) else $error("immediate load wrong");
  chk_move_flags_kept: assert property (take && issue_op inside {5'h01, 5'h03} |=>
    $stable(flags)) else $error("move altered a flag");
  chk_union_imm_zero: assert property (take && issue_op == 5'h05 |=>
    acc_out == ($past(acc_out) | $past(issue_imm)) && zero_flag == (acc_out == 8'h00)
    && $stable({signed_wrap_flag, nibble_carry_flag, carry_flag}))
    else $error("immediate union result or flags wrong");
  chk_return_dummy_cycle: assert property (take && issue_op inside {5'h07, 5'h08, 5'h09}
    |=> !issue_ready && retire ##1 issue_ready) else $error("return lacks one dummy cycle");
  chk_exit_irq_on: assert property (take && issue_op == 5'h09 |=>
    global_irq_enable && $stable(flags)) else $error("interrupt exit left irq disabled");
  chk_ret_imm_acc: assert property (take && issue_op == 5'h08 |=>
    acc_out == $past(issue_imm) && $stable(flags)) else $error("return constant wrong");
  chk_skip_pc_two: assert property (take && issue_op inside {5'h14, 5'h15} |=>
    retire && (discard_fetch ? (pc_out == $past(pc_out) + 2'd2 && !issue_ready)
    : (pc_out == $past(pc_out) + 1'b1 && issue_ready))) else $error("skip timing wrong");
  chk_dec_acc_skip: assert property (take && issue_op == 5'h15 |=>
    discard_fetch == (acc_out == 8'h00) && $stable(flags)) else $error("skip not on zero");
  chk_rot_carry_only: assert property (take && issue_op inside {5'h0C, 5'h0D, 5'h10, 5'h11}
    |=> $stable({signed_wrap_flag, zero_flag, nibble_carry_flag}))
    else $error("rotate through carry touched another flag");
  cov_skip: cover property (discard_fetch);
  cov_exit: cover property (take && issue_op == 5'h09);
  cov_sub: cover property (take && issue_op == 5'h13);
endmodule : aie_exec_props

bind aie_exec aie_exec_props #(.PC_W(PC_W)) u_props (.ref_clk, .rst_b, .issue_valid,
  .issue_op, .issue_imm, .issue_ready, .pc_out, .acc_out, .carry_flag, .nibble_carry_flag,
  .zero_flag, .signed_wrap_flag, .global_irq_enable, .discard_fetch, .retire);

/* tb_aie_exec.sv */
module tb_aie_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_b, issue_valid, call_valid, reg_wr, reg_rd, issue_ready, retire;
  logic carry_flag, nibble_carry_flag, zero_flag, signed_wrap_flag, global_irq_enable;
  logic discard_fetch, s_ready, s_disc, s_ret, c, cn, thru, hc, ov;
  logic [4:0] issue_op;
  logic [7:0] issue_imm, issue_addr, reg_addr, reg_wdata, reg_rdata, acc_out, r, mn;
  logic [11:0] call_target, pc_out, pc0, pcr;
  logic [8:0] sum;
  logic [7:0] sa [3] = '{8'h50, 8'h80, 8'h10};
  logic [7:0] sm [3] = '{8'h50, 8'h01, 8'h20};
  logic sc [3] = '{1'b1, 1'b1, 1'b0};
  int miscompares, n_checks, k;

  aie_exec uut (.ref_clk(ref_clk), .rst_b(rst_b), .issue_valid(issue_valid),
    .issue_op(issue_op), .issue_imm(issue_imm), .issue_addr(issue_addr),
    .issue_ready(issue_ready), .call_valid(call_valid), .call_target(call_target),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pc_out(pc_out), .acc_out(acc_out), .carry_flag(carry_flag),
    .nibble_carry_flag(nibble_carry_flag), .zero_flag(zero_flag),
    .signed_wrap_flag(signed_wrap_flag), .global_irq_enable(global_irq_enable),
    .discard_fetch(discard_fetch), .retire(retire));

  // Core clock at 250 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic c8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : c8

  task automatic c1(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : c1

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample mid-cycle there.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    c8(reg_rdata, exp, what);
    @(negedge ref_clk);
    c8(reg_rdata, 8'h00, "rdata idle");
  endtask : rd

  // Pulses last one cycle, so they are captured right after the taking edge.
  task automatic run(input logic [4:0] op, input logic [7:0] a, input logic [7:0] imm);
    @(negedge ref_clk);
    pc0 = pc_out;
    @(posedge ref_clk);
    issue_op <= op;
    issue_addr <= a;
    issue_imm <= imm;
    issue_valid <= 1'b1;
    @(posedge ref_clk);
    issue_valid <= 1'b0;
    @(negedge ref_clk);
    s_ready = issue_ready;
    s_disc = discard_fetch;
    s_ret = retire;
    for (int i = 0; i < 4 && issue_ready !== 1'b1; i++) @(negedge ref_clk);
  endtask : run

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // Cuts a hung run short; the tests need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  // Main sequence.
  initial begin
    {issue_valid, call_valid, reg_wr, reg_rd, issue_op} = 9'h000;
    {issue_imm, issue_addr, reg_addr, reg_wdata, call_target} = 44'h0;
    {miscompares, n_checks} = 64'h0;
    rst_b = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(8'hF0, 8'h00, "acc rst");
    rd(8'hF1, 8'h00, "stat rst");
    rd(8'hF8, 8'h00, "unmapped");
    wr(8'hF1, 8'h0F);
    run(5'h02, 8'h00, 8'hA5);
    c8(acc_out, 8'hA5, "imm load");
    run(5'h00, 8'h00, 8'h00);
    c8(pc_out[7:0], pc0[7:0] + 8'h01, "idle pc");
    c1(s_ret, 1'b1, "retire");
    run(5'h03, 8'h10, 8'h00);
    rd(8'h10, 8'hA5, "store");
    wr(8'h11, 8'h3C);
    run(5'h01, 8'h11, 8'h00);
    c8(acc_out, 8'h3C, "mem load");
    rd(8'hF1, 8'h0F, "move flags");
    wr(8'hF1, 8'h0B);
    run(5'h02, 8'h00, 8'h00);
    run(5'h05, 8'h00, 8'h00);
    c1(zero_flag, 1'b1, "union zero");
    run(5'h04, 8'h11, 8'h00);
    rd(8'hF1, 8'h0B, "union flags");
    wr(8'h12, 8'h41);
    run(5'h06, 8'h12, 8'h00);
    rd(8'h12, 8'h7D, "union mem");
    c8(acc_out, 8'h3C, "union keep acc");
    $display("moves and unions done");
    for (int op = 10; op < 18; op++) begin
      c = op[0];
      wr(8'h20, 8'h96);
      wr(8'hF1, {7'h07, c});
      run(5'h02, 8'h00, 8'h55);
      run(op[4:0], 8'h20, 8'h00);
      thru = (op == 12 || op == 13 || op == 16 || op == 17);
      r = (op < 14) ? {8'h96 << 1} | {7'h00, thru ? c : 1'b1} : {thru ? c : 1'b0, 7'h4B};
      cn = !thru ? c : (op < 14);
      c8(acc_out, c ? r : 8'h55, "rot acc");
      rd(8'h20, c ? 8'h96 : r, "rot mem");
      rd(8'hF1, {7'h07, cn}, "rot flags");
    end
    $display("rotates done");
    for (int i = 0; i < 6; i++) begin
      k = i % 3;
      wr(8'h21, sm[k]);
      wr(8'hF1, {7'h00, sc[k]});
      run(5'h02, 8'h00, sa[k]);
      run(i < 3 ? 5'h12 : 5'h13, 8'h21, 8'h00);
      mn = ~sm[k];
      sum = sa[k] + mn + sc[k];
      hc = (sa[k][3:0] + mn[3:0] + sc[k]) > 15;
      ov = (sa[k][7] == mn[7]) && (sum[7] != sa[k][7]);
      c8(acc_out, i < 3 ? sum[7:0] : sa[k], "sub acc");
      rd(8'h21, i < 3 ? sm[k] : sum[7:0], "sub mem");
      rd(8'hF1, {4'h0, ov, sum[7:0] == 8'h00, hc, sum[8]}, "sub flags");
      c8({4'h0, signed_wrap_flag, zero_flag, nibble_carry_flag, carry_flag},
        {4'h0, ov, sum[7:0] == 8'h00, hc, sum[8]}, "sub pins");
    end
    $display("subtracts done");
    wr(8'hF1, 8'h0F);
    wr(8'h30, 8'h02);
    run(5'h14, 8'h30, 8'h00);
    c8(pc_out[7:0], pc0[7:0] + 8'h01, "no skip pc");
    c1(s_disc, 1'b0, "no skip");
    run(5'h14, 8'h30, 8'h00);
    c8(pc_out[7:0], pc0[7:0] + 8'h02, "skip pc");
    c1(s_disc, 1'b1, "skip discard");
    c1(s_ready, 1'b0, "skip dummy");
    rd(8'h30, 8'h00, "dec mem");
    rd(8'hF1, 8'h0F, "dec flags");
    wr(8'h31, 8'h01);
    run(5'h15, 8'h31, 8'h00);
    c8(acc_out, 8'h00, "dec acc");
    c1(s_disc, 1'b1, "dec acc skip");
    rd(8'h31, 8'h01, "dec acc mem");
    $display("skips done");
    for (int op = 7; op < 10; op++) begin
      pcr = pc_out;
      @(posedge ref_clk);
      call_target <= 12'h123;
      call_valid <= 1'b1;
      @(posedge ref_clk);
      call_valid <= 1'b0;
      run(op[4:0], 8'h00, 8'h5A);
      c8(pc_out[7:0], pcr[7:0] + 8'h01, "pop pc");
      c1(s_ready, 1'b0, "ret dummy");
      if (op == 8) c8(acc_out, 8'h5A, "ret acc");
      if (op == 9) c1(global_irq_enable, 1'b1, "irq on");
    end
    rd(8'hF1, 8'h1F, "ret flags");
    rd(8'hF2, pcr[7:0] + 8'h01, "pc low");
    rd(8'hF3, {4'h0, pcr[11:8]}, "pc high");
    rd(8'hF4, 8'h00, "phase");
    run(5'h1F, 8'h00, 8'h00);
    c8(pc_out[7:0], pc0[7:0] + 8'h01, "undef pc");
    $display("returns done");
    results();
  end
endmodule : tb_aie_exec
